// ---- core/ivr_params.svh ----
// Constants for the interrupt vector relocation block: offsets, fields, reset values and counts.
`ifndef IVR_PARAMS_SVH
`define IVR_PARAMS_SVH

`define IVR_CTRL_OFFSET 12'h000
`define IVR_UNLOCK_BIT 0
`define IVR_SELECT_BIT 1
`define IVR_CTRL_RESET 8'h00
`define IVR_UNLOCK_CYCLES 3'd4
`define IVR_VECTOR_COUNT 5'd27
`define IVR_VECTOR_STRIDE 16'h0002
`define IVR_LAST_VECTOR 16'h0034
`define IVR_APP_RESET_ADDR 16'h0000
`define IVR_IRQ_TABLE_OFFSET 16'h0002
`define IVR_BOOT_START_SZ00 16'h1c00
`define IVR_BOOT_START_SZ01 16'h1e00
`define IVR_BOOT_START_SZ10 16'h1f00
`define IVR_BOOT_START_SZ11 16'h1f80
`define IVR_FUSE_UNPROGRAMMED 1'b1

`endif

// ---- core/ivr_pkg.sv ----
// Types shared by the interrupt vector relocation block.
package ivr_pkg;

  typedef logic [15:0] ivr_addr_t;

  typedef enum logic [2:0] {
    IVR_IDLE = 3'b001,
    IVR_ARMED = 3'b010,
    IVR_WAIT_INSTR = 3'b100
  } ivr_state_e;

endpackage

// ---- core/ivr_unlock_timer.sv ----
// Unlock window timer and automatic interrupt blocking for vector table changes.
`include "ivr_params.svh"

module ivr_unlock_timer
  import ivr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic arm,
  input wire logic select_write,
  input wire logic instr_done,
  output logic unlock_armed,
  output logic irq_block
);

  ivr_state_e state_q;
  logic [2:0] count_q;

  // The window opens at the edge on which the unlock write takes effect.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= IVR_IDLE;
    end else begin
      case (state_q)
        IVR_IDLE: begin
          if (arm) begin
            state_q <= IVR_ARMED;
          end
        end
        IVR_ARMED: begin
          if (arm) begin
            state_q <= IVR_ARMED;
          end else if (select_write) begin
            state_q <= IVR_WAIT_INSTR;
          end else if (count_q == 3'd0) begin
            state_q <= IVR_IDLE;
          end
        end
        IVR_WAIT_INSTR: begin
          if (arm) begin
            state_q <= IVR_ARMED;
          end else if (instr_done) begin
            state_q <= IVR_IDLE;
          end
        end
        default: begin
          state_q <= IVR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 3'd0;
    end else if (arm) begin
      count_q <= `IVR_UNLOCK_CYCLES - 3'd1;
    end else if (state_q == IVR_ARMED && count_q != 3'd0) begin
      count_q <= count_q - 3'd1;
    end
  end

  assign unlock_armed = (state_q == IVR_ARMED);
  // Blocking is a separate gate; the core's global enable flag is never written here.
  assign irq_block = (state_q != IVR_IDLE);

endmodule

// ---- core/ivr_vector_map.sv ----
// Address arithmetic for the reset vector, the vector table base and single vector fetches.
`include "ivr_params.svh"

module ivr_vector_map
  import ivr_pkg::*;
(
  input wire logic vector_sel,
  input wire logic boot_reset_fuse,
  input wire logic [1:0] boot_size_fuses,
  input wire logic [4:0] vec_index,
  input wire ivr_addr_t exec_pc,
  output ivr_addr_t boot_start,
  output ivr_addr_t reset_addr,
  output ivr_addr_t table_addr,
  output ivr_addr_t fetch_addr,
  output logic vec_index_ok,
  output logic exec_in_boot
);

  function automatic ivr_addr_t boot_start_of(input logic [1:0] size);
    case (size)
      2'b00: boot_start_of = `IVR_BOOT_START_SZ00;
      2'b01: boot_start_of = `IVR_BOOT_START_SZ01;
      2'b10: boot_start_of = `IVR_BOOT_START_SZ10;
      default: boot_start_of = `IVR_BOOT_START_SZ11;
    endcase
  endfunction

  ivr_addr_t base;

  assign boot_start = boot_start_of(boot_size_fuses);
  // A fuse reading one is unprogrammed.
  assign reset_addr = (boot_reset_fuse == `IVR_FUSE_UNPROGRAMMED) ? `IVR_APP_RESET_ADDR : boot_start;
  assign base = vector_sel ? boot_start : `IVR_APP_RESET_ADDR;
  assign table_addr = base + `IVR_IRQ_TABLE_OFFSET;
  assign vec_index_ok = (vec_index < `IVR_VECTOR_COUNT);
  assign fetch_addr = base + ({11'h000, vec_index} * `IVR_VECTOR_STRIDE);
  assign exec_in_boot = (exec_pc >= boot_start);

endmodule

// ---- core/ivr_top.sv ----
// Interrupt vector relocation: control register on APB, unlock sequence and interrupt gating.
`include "ivr_params.svh"

module ivr_top
  import ivr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_reset_fuse,
  input wire logic [1:0] boot_size_fuses,
  input wire logic app_section_lock_bit,
  input wire logic boot_section_lock_bit,
  input wire logic global_int_enable,
  input wire logic instr_done,
  input wire ivr_addr_t exec_pc,
  input wire logic [4:0] vec_index,
  output ivr_addr_t reset_vector_addr,
  output ivr_addr_t vector_table_addr,
  output ivr_addr_t vector_fetch_addr,
  output logic vector_index_valid,
  output logic vector_base_select,
  output logic irq_block,
  output logic irq_service_permit
);

  logic [1:0] fuse_rst_sync_q;
  logic [3:0] fuse_sz_sync_q;
  logic [1:0] app_lock_sync_q;
  logic [1:0] boot_lock_sync_q;
  logic boot_reset_fuse_s;
  logic [1:0] boot_size_fuses_s;
  logic app_lock_s;
  logic boot_lock_s;

  logic vector_sel_q;
  logic unlock_armed;
  logic ctrl_hit;
  logic ctrl_wr;
  logic arm;
  logic sel_accept;
  logic lock_suppress;
  logic [31:0] prdata_q;
  logic [7:0] ctrl_read;
  localparam logic [7:0] ctrl_reset_c = `IVR_CTRL_RESET;

  ivr_addr_t boot_start;
  ivr_addr_t reset_addr_d;
  ivr_addr_t table_addr_d;
  ivr_addr_t fetch_addr_d;
  logic vec_ok_d;
  logic exec_in_boot;
  ivr_addr_t reset_vector_addr_q;
  ivr_addr_t vector_table_addr_q;
  ivr_addr_t vector_fetch_addr_q;
  logic vector_index_valid_q;

  // Fuses and lock bits arrive from outside the clock domain; they reset to the unprogrammed level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_rst_sync_q <= 2'b11;
      fuse_sz_sync_q <= 4'hf;
      app_lock_sync_q <= 2'b11;
      boot_lock_sync_q <= 2'b11;
    end else begin
      fuse_rst_sync_q <= {fuse_rst_sync_q[0], boot_reset_fuse};
      fuse_sz_sync_q <= {fuse_sz_sync_q[1:0], boot_size_fuses};
      app_lock_sync_q <= {app_lock_sync_q[0], app_section_lock_bit};
      boot_lock_sync_q <= {boot_lock_sync_q[0], boot_section_lock_bit};
    end
  end

  assign boot_reset_fuse_s = fuse_rst_sync_q[1];
  assign boot_size_fuses_s = fuse_sz_sync_q[3:2];
  assign app_lock_s = app_lock_sync_q[1];
  assign boot_lock_s = boot_lock_sync_q[1];

  // Zero wait states; read data is captured in the setup cycle so it comes from a flop.
  assign ctrl_hit = (paddr == `IVR_CTRL_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !ctrl_hit;
  assign ctrl_wr = psel && penable && pwrite && ctrl_hit;
  assign arm = ctrl_wr && pwdata[`IVR_UNLOCK_BIT];
  // A write that sets the unlock bit never changes the select bit in the same write.
  assign sel_accept = ctrl_wr && !pwdata[`IVR_UNLOCK_BIT] && unlock_armed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_sel_q <= ctrl_reset_c[`IVR_SELECT_BIT];
    end else if (sel_accept) begin
      vector_sel_q <= pwdata[`IVR_SELECT_BIT];
    end
  end

  always_comb begin
    ctrl_read = `IVR_CTRL_RESET;
    ctrl_read[`IVR_SELECT_BIT] = vector_sel_q;
    ctrl_read[`IVR_UNLOCK_BIT] = unlock_armed;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= ctrl_hit ? {24'h00_0000, ctrl_read} : 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;

  ivr_unlock_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .arm(arm),
    .select_write(sel_accept),
    .instr_done(instr_done),
    .unlock_armed(unlock_armed),
    .irq_block(irq_block)
  );

  ivr_vector_map u_map (
    .vector_sel(vector_sel_q),
    .boot_reset_fuse(boot_reset_fuse_s),
    .boot_size_fuses(boot_size_fuses_s),
    .vec_index(vec_index),
    .exec_pc(exec_pc),
    .boot_start(boot_start),
    .reset_addr(reset_addr_d),
    .table_addr(table_addr_d),
    .fetch_addr(fetch_addr_d),
    .vec_index_ok(vec_ok_d),
    .exec_in_boot(exec_in_boot)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_vector_addr_q <= `IVR_APP_RESET_ADDR;
      vector_table_addr_q <= `IVR_IRQ_TABLE_OFFSET;
      vector_fetch_addr_q <= `IVR_APP_RESET_ADDR;
      vector_index_valid_q <= 1'b0;
    end else begin
      reset_vector_addr_q <= reset_addr_d;
      vector_table_addr_q <= table_addr_d;
      vector_fetch_addr_q <= vec_ok_d ? fetch_addr_d : vector_fetch_addr_q;
      vector_index_valid_q <= vec_ok_d;
    end
  end

  assign reset_vector_addr = reset_vector_addr_q;
  assign vector_table_addr = vector_table_addr_q;
  assign vector_fetch_addr = vector_fetch_addr_q;
  assign vector_index_valid = vector_index_valid_q;
  assign vector_base_select = vector_sel_q;

  // A lock bit reading zero is programmed. Suppression is combinational so it acts on the current fetch.
  assign lock_suppress = (vector_sel_q && !app_lock_s && !exec_in_boot) ||
                         (!vector_sel_q && !boot_lock_s && exec_in_boot);
  assign irq_service_permit = global_int_enable && !irq_block && !lock_suppress;

  // Counts armed cycles after the arming edge; a clean window holds exactly four of them.
  logic [3:0] armed_run_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_run_q <= 4'h0;
    end else if (unlock_armed && !arm) begin
      armed_run_q <= armed_run_q + 4'h1;
    end else begin
      armed_run_q <= 4'h0;
    end
  end

  chk_select_needs_unlock: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_wr && !unlock_armed) |=> $stable(vector_sel_q))
    else $error("vector select changed without an armed unlock");

  chk_select_accepted: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_wr && !pwdata[`IVR_UNLOCK_BIT] && unlock_armed) |=> (vector_sel_q == $past(pwdata[`IVR_SELECT_BIT])))
    else $error("vector select write inside the window was not taken");

  chk_unlock_expires: assert property (@(posedge pclk) disable iff (!presetn)
    (arm ##1 (!ctrl_wr) [*4]) |=> !unlock_armed)
    else $error("unlock did not clear four cycles after arming");

  chk_unlock_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (arm ##1 (!ctrl_wr) [*3]) |-> unlock_armed)
    else $error("unlock cleared before four cycles");

  chk_unlock_run_bound: assert property (@(posedge pclk) disable iff (!presetn)
    armed_run_q <= 4'd4)
    else $error("unlock stayed armed too long");

  chk_select_ends_unlock: assert property (@(posedge pclk) disable iff (!presetn)
    sel_accept |=> (!unlock_armed && irq_block))
    else $error("select write did not close the unlock window");

  chk_block_while_armed: assert property (@(posedge pclk) disable iff (!presetn)
    unlock_armed |-> (irq_block && !irq_service_permit))
    else $error("interrupts not blocked during unlock");

  chk_block_release: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_block && !unlock_armed && instr_done && !arm) |=> !irq_block)
    else $error("block not released after the following instruction");

  chk_expire_release: assert property (@(posedge pclk) disable iff (!presetn)
    (arm ##1 (!ctrl_wr) [*4]) |=> !irq_block)
    else $error("block outlived an unused unlock window");

  chk_permit_needs_gie: assert property (@(posedge pclk) disable iff (!presetn)
    irq_service_permit |-> global_int_enable)
    else $error("service permitted without global enable");

  chk_app_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (vector_sel_q && !app_lock_s && !exec_in_boot) |-> !irq_service_permit)
    else $error("interrupt allowed in locked application section");

  chk_boot_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (!vector_sel_q && !boot_lock_s && exec_in_boot) |-> !irq_service_permit)
    else $error("interrupt allowed in locked boot section");

  chk_reset_address: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (reset_vector_addr_q == ($past(boot_reset_fuse_s) ? `IVR_APP_RESET_ADDR : $past(boot_start))))
    else $error("reset address does not follow the boot reset fuse");

  chk_table_address: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (vector_table_addr_q == (($past(vector_sel_q) ? $past(boot_start) : 16'h0000) + 16'h0002)))
    else $error("vector table start address wrong");

  chk_last_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (!vector_sel_q && vec_index == 5'd26) |=> (vector_fetch_addr_q == `IVR_LAST_VECTOR || $changed(vector_sel_q)))
    else $error("last vector address wrong");

  // The checks below watch the timer through its outputs only, so they hold however the state is coded.
  chk_arm_opens_window: assert property (@(posedge pclk) disable iff (!presetn)
    arm |=> (unlock_armed && irq_block))
    else $error("unlock write did not open the window");

  chk_arm_keeps_select: assert property (@(posedge pclk) disable iff (!presetn)
    arm |=> $stable(vector_sel_q))
    else $error("arming write changed the select bit");

  chk_wait_holds_block: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_block && !unlock_armed && !instr_done && !arm) |=> irq_block)
    else $error("block released before the following instruction");

  chk_idle_stays_open: assert property (@(posedge pclk) disable iff (!presetn)
    (!irq_block && !arm) |=> !irq_block)
    else $error("block raised without an unlock write");

  chk_permit_when_free: assert property (@(posedge pclk) disable iff (!presetn)
    (global_int_enable && !irq_block && !lock_suppress) |-> irq_service_permit)
    else $error("service withheld although nothing blocks it");

  chk_permit_needs_free: assert property (@(posedge pclk) disable iff (!presetn)
    irq_service_permit |-> !irq_block)
    else $error("service permitted during automatic block");

  chk_block_after_select: assert property (@(posedge pclk) disable iff (!presetn)
    sel_accept |=> (irq_block && !irq_service_permit))
    else $error("interrupts served right after the select write");

  chk_rearm_restarts: assert property (@(posedge pclk) disable iff (!presetn)
    ((unlock_armed && arm) ##1 (!ctrl_wr) [*3]) |-> unlock_armed)
    else $error("re-arming did not restart the window");

  chk_index_valid: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (vector_index_valid_q == ($past(vec_index) < `IVR_VECTOR_COUNT)))
    else $error("vector index valid flag wrong");

  chk_app_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    (vec_ok_d && !vector_sel_q) |=> (vector_fetch_addr_q == {10'h000, $past(vec_index), 1'b0}))
    else $error("application vector fetch address wrong");

  chk_boot_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    (vec_ok_d && vector_sel_q) |=> (vector_fetch_addr_q == $past(boot_start) + {$past(vec_index), 1'b0}))
    else $error("relocated vector fetch address wrong");

  chk_fetch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !vec_ok_d |=> $stable(vector_fetch_addr_q))
    else $error("fetch address moved on an invalid index");

  chk_table_app: assert property (@(posedge pclk) disable iff (!presetn)
    !vector_sel_q |=> (vector_table_addr_q == `IVR_IRQ_TABLE_OFFSET))
    else $error("application table start wrong");

  chk_table_boot: assert property (@(posedge pclk) disable iff (!presetn)
    vector_sel_q |=> (vector_table_addr_q == $past(boot_start) + `IVR_IRQ_TABLE_OFFSET))
    else $error("relocated table start wrong");

  chk_boot_reset_start: assert property (@(posedge pclk) disable iff (!presetn)
    !boot_reset_fuse_s |=> (reset_vector_addr_q == $past(boot_start)))
    else $error("programmed fuse did not select the boot start");

  chk_boot_start_code: assert property (@(posedge pclk) disable iff (!presetn)
    (boot_size_fuses_s == 2'b00) |-> (boot_start == `IVR_BOOT_START_SZ00))
    else $error("boot start does not follow the size fuses");

  chk_unmapped_write: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !ctrl_hit) |=> $stable(vector_sel_q))
    else $error("unmapped write changed the select bit");

  chk_read_image: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && ctrl_hit) |=> (prdata_q[1:0] == {$past(vector_sel_q), $past(unlock_armed)}))
    else $error("control read image wrong");

  cov_move_vectors: cover property (@(posedge pclk) disable iff (!presetn)
    arm ##[1:4] sel_accept ##[1:20] !irq_block);

  cov_window_expired: cover property (@(posedge pclk) disable iff (!presetn)
    arm ##1 (!ctrl_wr) [*4] ##1 !unlock_armed);

  cov_lock_suppress: cover property (@(posedge pclk) disable iff (!presetn)
    global_int_enable && !irq_block && lock_suppress);

  cov_boot_reset: cover property (@(posedge pclk) disable iff (!presetn)
    !boot_reset_fuse_s && vector_sel_q);

  cov_rearm: cover property (@(posedge pclk) disable iff (!presetn)
    unlock_armed && arm);

endmodule

// ---- sim/ivr_top_tb_top.sv ----
// Self-checking testbench for the interrupt vector relocation block, driven over APB.
`include "ivr_params.svh"

module ivr_top_tb_top
  import ivr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic boot_reset_fuse = 1'b1;
  logic [1:0] boot_size_fuses = 2'b00;
  logic app_section_lock_bit = 1'b1;
  logic boot_section_lock_bit = 1'b1;
  logic global_int_enable = 1'b1;
  logic instr_done = 1'b0;
  ivr_addr_t exec_pc = 16'h0100;
  logic [4:0] vec_index = 5'h00;
  ivr_addr_t reset_vector_addr;
  ivr_addr_t vector_table_addr;
  ivr_addr_t vector_fetch_addr;
  logic vector_index_valid;
  logic vector_base_select;
  logic irq_block;
  logic irq_service_permit;
  logic [31:0] rdata;
  logic err;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  ivr_addr_t starts [4];

  always #10 pclk = ~pclk;

  ivr_top ivr_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_reset_fuse(boot_reset_fuse), .boot_size_fuses(boot_size_fuses),
    .app_section_lock_bit(app_section_lock_bit), .boot_section_lock_bit(boot_section_lock_bit),
    .global_int_enable(global_int_enable), .instr_done(instr_done), .exec_pc(exec_pc),
    .vec_index(vec_index), .reset_vector_addr(reset_vector_addr), .vector_table_addr(vector_table_addr),
    .vector_fetch_addr(vector_fetch_addr), .vector_index_valid(vector_index_valid),
    .vector_base_select(vector_base_select), .irq_block(irq_block), .irq_service_permit(irq_service_permit)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Entered at a rising edge. Penable is only lowered at the end, so back-to-back calls never
  // assign it twice in one time step, and psel stays high when another transfer follows.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic last);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the answer.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (last) begin
      psel <= 1'b0;
    end
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The whole run needs about a hundred cycles; the ceiling leaves ample margin.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    starts = '{`IVR_BOOT_START_SZ00, `IVR_BOOT_START_SZ01, `IVR_BOOT_START_SZ10, `IVR_BOOT_START_SZ11};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, `IVR_CTRL_OFFSET, 32'h0000_0000, 1'b0);
    check("control reset", rdata, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000, 1'b0);
    check("unmapped read", rdata, 32'h0000_0000);
    check("unmapped error", err, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_0001, 1'b0);
    check("unmapped write error", err, 1'b1);
    apb(1'b1, `IVR_CTRL_OFFSET, 32'h0000_0002, 1'b1);
    @(posedge pclk);
    #1;
    check("select unarmed", vector_base_select, 1'b0);
    check("no block", irq_block, 1'b0);
    check("reset addr", reset_vector_addr, `IVR_APP_RESET_ADDR);
    check("table addr", vector_table_addr, `IVR_IRQ_TABLE_OFFSET);
    done("reset");
    @(posedge pclk);
    apb(1'b1, `IVR_CTRL_OFFSET, 32'h0000_0001, 1'b0);
    apb(1'b0, `IVR_CTRL_OFFSET, 32'h0000_0000, 1'b1);
    check("unlock armed", rdata, 32'h0000_0001);
    #1;
    check("block armed", irq_block, 1'b1);
    check("permit armed", irq_service_permit, 1'b0);
    @(posedge pclk);
    #1;
    check("block last", irq_block, 1'b1);
    @(posedge pclk);
    #1;
    check("block end", irq_block, 1'b0);
    check("permit end", irq_service_permit, 1'b1);
    @(posedge pclk);
    apb(1'b0, `IVR_CTRL_OFFSET, 32'h0000_0000, 1'b1);
    check("unlock expired", rdata, 32'h0000_0000);
    done("unlock timeout");
    @(posedge pclk);
    apb(1'b1, `IVR_CTRL_OFFSET, 32'h0000_0001, 1'b0);
    apb(1'b1, `IVR_CTRL_OFFSET, 32'h0000_0002, 1'b1);
    repeat (4) @(posedge pclk);
    #1;
    check("select moved", vector_base_select, 1'b1);
    check("block held", irq_block, 1'b1);
    @(posedge pclk);
    instr_done <= 1'b1;
    @(posedge pclk);
    instr_done <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    check("block released", irq_block, 1'b0);
    @(posedge pclk);
    apb(1'b0, `IVR_CTRL_OFFSET, 32'h0000_0000, 1'b1);
    check("control moved", rdata, 32'h0000_0002);
    done("move");
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      boot_reset_fuse <= 1'b0;
      boot_size_fuses <= 2'(k);
      vec_index <= 5'd26;
      repeat (5) @(posedge pclk);
      #1;
      check("boot reset addr", reset_vector_addr, starts[k]);
      check("moved table", vector_table_addr, starts[k] + `IVR_IRQ_TABLE_OFFSET);
      check("moved fetch", vector_fetch_addr, starts[k] + `IVR_LAST_VECTOR);
      check("index ok", vector_index_valid, 1'b1);
    end
    @(posedge pclk);
    boot_reset_fuse <= 1'b1;
    boot_size_fuses <= 2'b00;
    vec_index <= `IVR_VECTOR_COUNT;
    repeat (5) @(posedge pclk);
    #1;
    check("app reset addr", reset_vector_addr, `IVR_APP_RESET_ADDR);
    check("index past end", vector_index_valid, 1'b0);
    done("fuses");
    @(posedge pclk);
    app_section_lock_bit <= 1'b0;
    repeat (5) @(posedge pclk);
    #1;
    check("app code locked", irq_service_permit, 1'b0);
    @(posedge pclk);
    exec_pc <= `IVR_BOOT_START_SZ00;
    repeat (2) @(posedge pclk);
    #1;
    check("boot code free", irq_service_permit, 1'b1);
    @(posedge pclk);
    apb(1'b1, `IVR_CTRL_OFFSET, 32'h0000_0001, 1'b0);
    apb(1'b1, `IVR_CTRL_OFFSET, 32'h0000_0000, 1'b1);
    @(posedge pclk);
    instr_done <= 1'b1;
    @(posedge pclk);
    instr_done <= 1'b0;
    app_section_lock_bit <= 1'b1;
    boot_section_lock_bit <= 1'b0;
    vec_index <= 5'd26;
    repeat (5) @(posedge pclk);
    #1;
    check("select back", vector_base_select, 1'b0);
    check("flash fetch", vector_fetch_addr, `IVR_LAST_VECTOR);
    check("boot code locked", irq_service_permit, 1'b0);
    @(posedge pclk);
    exec_pc <= 16'h0100;
    repeat (2) @(posedge pclk);
    #1;
    check("app code free", irq_service_permit, 1'b1);
    @(posedge pclk);
    global_int_enable <= 1'b0;
    @(posedge pclk);
    #1;
    check("global disable", irq_service_permit, 1'b0);
    done("locks");
    stop_test();
  end
endmodule
